// [logic/spi_port_pkg.sv]
`default_nettype none
package spi_port_pkg;
    // Register offsets
    localparam logic [15:0] FLAG_OFFSET = 16'h00F8;
    localparam logic [15:0] CMD_OFFSET = 16'h00FD;
    localparam logic [15:0] SELECTOR_OFFSET = 16'h2080;
    localparam logic [15:0] STROBE_OFFSET = 16'h2081;
    localparam logic [15:0] IRQ_ENABLE_OFFSET = 16'h2701;
    localparam logic [15:0] STATUS_OFFSET = 16'h2708;
    localparam logic [15:0] PORT_CTRL_OFFSET = 16'h270C;
    // Field positions
    localparam int FLAG_BIT = 7;
    localparam int IRQ_ENABLE_BIT = 7;
    localparam int PORT_ENABLE_BIT = 4;
    localparam int SAFE_BIT = 3;
    localparam int STAT_ERR = 7;
    localparam int STAT_RPAR = 6;
    localparam int STAT_WPAR = 5;
    localparam int STAT_MODE = 1;
    localparam int STAT_READY = 0;
    // Reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam logic IRQ_ENABLE_RESET = 1'b0;
    localparam logic PORT_ENABLE_RESET = 1'b1;
    localparam logic SAFE_RESET = 1'b0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // Write window in protected mode
    localparam logic [15:0] SAFE_LO = 16'h0400;
    localparam logic [15:0] SAFE_HI = 16'h040F;
    // Flash mode entry codes
    localparam logic [7:0] SEL_ERASE = 8'hD1;
    localparam logic [7:0] SEL_READBACK = 8'h2E;
    localparam logic [7:0] STROBE_KEY = 8'h96;
    localparam logic [3:0] FLASH_KEY = 4'h2;
    // Byte positions within a transaction, and the status count for a short one
    localparam logic [2:0] IDX_ADDR_HI = 3'h0;
    localparam logic [2:0] IDX_ADDR_LO = 3'h1;
    localparam logic [2:0] IDX_CMD = 3'h2;
    localparam logic [2:0] IDX_STATUS = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] SHORT_COUNT = 3'h7;
    typedef enum logic [1:0] {
        MEM_IDLE = 2'b00,
        MEM_WRITE = 2'b01,
        MEM_READ = 2'b10
    } mem_state_t;
endpackage : spi_port_pkg
`default_nettype wire

// [logic/spi_slave_memory_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Protected mode allows writes only 0x400-0x40F
// RULE2: One-byte transaction is command, raises interrupt
// RULE3: Frame: address, command, status, then data
// RULE4: Read command streams data, interrupts unless 0x80
// RULE5: Write command stores data, interrupts unless 0x00
// RULE6: Hardware sets flag; software clears writing zero
// RULE7: Protected bit resets low, blocks other writes
// RULE8: Status bit 7 reports previous transfer failure
// RULE9: Status bit 6 is parity of sent bytes
// RULE10: Status bit 5 is parity of received bytes
// RULE11: Status bits 4:2 count data; short gives 111
// RULE12: Bit 1 flash mode gated by test; bit 0 ready
// RULE13: Flash mode routes every access to flash
// RULE14: Flash word committed after odd byte arrives
// RULE15: Large flash: one-byte transaction sets bank
// RULE16: Host writes flash with six-byte 0x00 transactions
// RULE17: Flash reads use 0x80; four-byte write polls
// RULE18: Entry needs emulation, no boot, unlocked, key
// RULE19: Selector and strobe writable only from link
// RULE20: Selector 0xD1 erase, 0x2E readback if unlocked
// RULE21: Strobe 0x96 enters; any strobe clears selector
// RULE22: Entry halts processor, resets flash, may erase
// RULE23: Deselected port idles, output released
// RULE24: Command top bit selects read or write
// RULE25: Bytes MSB first, sampled on rising edge
module spi_slave_memory_port
    import spi_port_pkg::*;
#(
    parameter bit LARGE_FLASH = 1'b1,
    parameter int FIFO_DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    output logic link_dout_oe_n,
    input wire logic test_pin,
    input wire logic emulation_enable_pin,
    input wire logic boot_phase_flag,
    input wire logic readback_lock,
    input wire logic [3:0] flash_write_key,
    input wire logic flash_ready,
    input wire logic [15:0] mpu_addr,
    input wire logic mpu_wr,
    input wire logic mpu_rd,
    input wire logic [7:0] mpu_wdata,
    output logic [7:0] mpu_rdata,
    output logic mpu_irq,
    output logic mem_req,
    output logic mem_we,
    output logic mem_word,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic [1:0] flash_bank_select,
    output logic flash_programming_mode,
    output logic flash_ctrl_reset,
    output logic mass_erase_start
);
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(p + PW'(1));
    endfunction : ptr_inc

    // Pin synchronisers
    logic [1:0] sel_s;
    logic [2:0] clk_s;
    logic [1:0] din_s;
    logic [1:0] test_s;
    logic [1:0] emu_s;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_s <= 2'h3;
            clk_s <= 3'h0;
            din_s <= 2'h0;
            test_s <= 2'h0;
            emu_s <= 2'h0;
        end else begin
            sel_s <= {sel_s[0], port_select_n};
            clk_s <= {clk_s[1:0], link_clk};
            din_s <= {din_s[0], link_din};
            test_s <= {test_s[0], test_pin};
            emu_s <= {emu_s[0], emulation_enable_pin};
        end
    end

    // Link side and register state
    logic active_reg, active_next, dout_reg, dout_next, oe_n_reg, oe_n_next;
    logic [2:0] bit_reg, bit_next, idx_reg, idx_next, dcnt_reg, dcnt_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next, byte0_reg, byte0_next;
    logic [7:0] cmd_reg, cmd_next, hcmd_reg, hcmd_next, stat_reg, stat_next;
    logic [7:0] selector_reg, selector_next, rdata_reg, rdata_next;
    logic [15:0] addr_reg, addr_next;
    logic wpar_reg, wpar_next, rpar_reg, rpar_next, err_reg, err_next;
    logic flag_reg, flag_next, ien_reg, ien_next, pen_reg, pen_next;
    logic safe_reg, safe_next, fmode_reg, fmode_next, irq_reg, irq_next;
    logic fcr_reg, fcr_next, erase_reg, erase_next;
    logic [1:0] bank_reg, bank_next;
    // Memory side state
    mem_state_t mstate_reg, mstate_next;
    logic mreq_reg, mreq_next, mwe_reg, mwe_next, mword_reg, mword_next;
    logic [15:0] maddr_reg, maddr_next, mwdata_reg, mwdata_next, rdaddr_reg, rdaddr_next;
    logic [7:0] lo_reg, lo_next, rbuf_reg, rbuf_next;
    logic rbuf_ok_reg, rbuf_ok_next, rdpend_reg, rdpend_next;
    logic [15:0] fifo_addr [FIFO_DEPTH];
    logic [7:0] fifo_data [FIFO_DEPTH];
    logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    // Handshakes between the two groups
    logic selected, rise, fall, end_evt, push, pop, take, rd_start, cap, strobe_hit;
    logic entry_ok, sel_valid, allowed, fifo_full, fifo_empty;
    logic [7:0] b, cap_val;

    assign selected = !sel_s[1] && pen_reg;
    assign rise = clk_s[1] && !clk_s[2];
    assign fall = !clk_s[1] && clk_s[2];
    assign end_evt = active_reg && !selected;
    assign fifo_full = (cnt_reg == CW'(FIFO_DEPTH));
    assign fifo_empty = (cnt_reg == '0);
    assign b = {shift_reg[6:0], din_s[1]}; // [RULE25]
    assign sel_valid = (selector_reg == SEL_ERASE) ||
        (selector_reg == SEL_READBACK && !readback_lock); // [RULE20]
    assign entry_ok = emu_s[1] && !boot_phase_flag && !readback_lock &&
        (flash_write_key == FLASH_KEY); // [RULE18]
    assign allowed = fmode_reg || !safe_reg ||
        (addr_reg >= SAFE_LO && addr_reg <= SAFE_HI); // [RULE1] [RULE7]

    always_comb begin
        {active_next, dout_next, oe_n_next, bit_next, idx_next} = {active_reg,
            dout_reg, oe_n_reg, bit_reg, idx_reg};
        {dcnt_next, shift_next, tx_next, byte0_next, cmd_next} = {dcnt_reg,
            shift_reg, tx_reg, byte0_reg, cmd_reg};
        {hcmd_next, stat_next, selector_next, addr_next} = {hcmd_reg, stat_reg,
            selector_reg, addr_reg};
        {wpar_next, rpar_next, err_next, flag_next, ien_next} = {wpar_reg,
            rpar_reg, err_reg, flag_reg, ien_reg};
        {pen_next, safe_next, fmode_next, bank_next} = {pen_reg, safe_reg,
            fmode_reg, bank_reg};
        rdata_next = rdata_reg;
        fcr_next = 1'b0;
        erase_next = 1'b0;
        irq_next = flag_reg && ien_reg;
        push = 1'b0;
        take = 1'b0;
        rd_start = 1'b0;
        cap = 1'b0;
        cap_val = cmd_reg;
        strobe_hit = 1'b0;
        // Processor register access; selector and strobe have no path here
        if (mpu_rd) begin // [RULE19]
            unique case (mpu_addr)
                FLAG_OFFSET: rdata_next = {flag_reg, 7'h00};
                CMD_OFFSET: rdata_next = hcmd_reg;
                IRQ_ENABLE_OFFSET: rdata_next = {ien_reg, 7'h00};
                STATUS_OFFSET: rdata_next = stat_reg;
                PORT_CTRL_OFFSET: rdata_next = {3'h0, pen_reg, safe_reg, 3'h0};
                default: rdata_next = 8'h00;
            endcase
        end
        if (mpu_wr) begin
            unique case (mpu_addr)
                FLAG_OFFSET: if (!mpu_wdata[FLAG_BIT]) flag_next = 1'b0; // [RULE6]
                IRQ_ENABLE_OFFSET: ien_next = mpu_wdata[IRQ_ENABLE_BIT];
                PORT_CTRL_OFFSET: begin
                    pen_next = mpu_wdata[PORT_ENABLE_BIT];
                    safe_next = mpu_wdata[SAFE_BIT]; // [RULE7]
                end
                default: ;
            endcase
        end
        if (!selected) begin
            oe_n_next = 1'b1; // [RULE23]
            dout_next = 1'b0;
            active_next = 1'b0;
            if (end_evt && (idx_reg != '0 || bit_reg != '0)) begin
                stat_next = {err_reg || bit_reg != '0, rpar_reg, wpar_reg, // [RULE8] [RULE9] [RULE10]
                    (idx_reg < IDX_DATA) ? SHORT_COUNT : dcnt_reg, // [RULE11]
                    fmode_reg && test_s[1], flash_ready}; // [RULE12]
                if (idx_reg == IDX_ADDR_LO && bit_reg == '0) begin
                    cap = 1'b1; // [RULE2]
                    cap_val = byte0_reg;
                    if (fmode_reg && LARGE_FLASH) bank_next = byte0_reg[1:0]; // [RULE15]
                end else if (idx_reg >= IDX_STATUS && cmd_reg[6:0] != 7'h00) begin
                    cap = 1'b1; // [RULE4] [RULE5]
                end
            end
            if (cap) begin
                hcmd_next = cap_val;
                if (!fmode_reg) flag_next = 1'b1; // [RULE6]
            end
            {bit_next, idx_next, dcnt_next, shift_next, tx_next} = '0;
            {wpar_next, rpar_next, err_next} = 3'h0;
        end else begin
            active_next = 1'b1;
            oe_n_next = 1'b0;
            if (fall) begin
                dout_next = tx_reg[7]; // [RULE25]
                tx_next = {tx_reg[6:0], 1'b0};
            end
            if (rise) begin
                shift_next = b;
                bit_next = 3'(bit_reg + 3'h1);
                if (bit_reg == '0 && idx_reg == IDX_DATA && cmd_reg[7])
                    rpar_next = rpar_reg ^ dout_reg ^ (^tx_reg[7:1]); // [RULE9]
                if (bit_reg == 3'h7) begin
                    wpar_next = wpar_reg ^ (^b); // [RULE10]
                    if (idx_reg < IDX_DATA) idx_next = 3'(idx_reg + 3'h1);
                    if (idx_reg == IDX_ADDR_HI) begin
                        byte0_next = b;
                        addr_next[15:8] = b; // [RULE3]
                    end else if (idx_reg == IDX_ADDR_LO) begin
                        addr_next[7:0] = b;
                    end else if (idx_reg == IDX_CMD) begin
                        cmd_next = b;
                        tx_next = stat_reg; // [RULE3]
                        if (b[7]) begin
                            rd_start = 1'b1; // [RULE24]
                            addr_next = 16'(addr_reg + 16'h0001);
                        end
                    end else begin
                        if (idx_reg == IDX_DATA) dcnt_next = 3'(dcnt_reg + 3'h1);
                        if (cmd_reg[7]) begin
                            if (rbuf_ok_reg) begin
                                tx_next = rbuf_reg; // [RULE4] [RULE17]
                                take = 1'b1;
                            end else begin
                                tx_next = 8'h00;
                                err_next = 1'b1; // [RULE8]
                            end
                            rd_start = 1'b1;
                            addr_next = 16'(addr_reg + 16'h0001);
                        end else if (idx_reg == IDX_DATA) begin
                            addr_next = 16'(addr_reg + 16'h0001); // [RULE5]
                            if (!allowed) begin
                                err_next = 1'b1; // [RULE1] [RULE7]
                            end else if (!fmode_reg && addr_reg == SELECTOR_OFFSET) begin
                                selector_next = b; // [RULE20]
                            end else if (!fmode_reg && addr_reg == STROBE_OFFSET) begin
                                strobe_hit = 1'b1;
                                selector_next = 8'h00; // [RULE21]
                                if (b == STROBE_KEY && sel_valid && entry_ok) begin
                                    fmode_next = 1'b1; // [RULE21] [RULE22]
                                    fcr_next = 1'b1;
                                    erase_next = (selector_reg == SEL_ERASE);
                                end
                            end else if (fifo_full) begin
                                err_next = 1'b1;
                            end else begin
                                push = 1'b1;
                            end
                        end
                    end
                end
            end
        end
        if (!test_s[1]) stat_next[STAT_MODE] = 1'b0; // [RULE12]
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {active_reg, dout_reg, bit_reg, idx_reg, dcnt_reg} <= '0;
            oe_n_reg <= 1'b1;
            {shift_reg, tx_reg, byte0_reg, cmd_reg, selector_reg, rdata_reg} <= '0;
            {addr_reg, wpar_reg, rpar_reg, err_reg} <= '0;
            hcmd_reg <= CMD_RESET;
            stat_reg <= STATUS_RESET;
            flag_reg <= FLAG_RESET;
            ien_reg <= IRQ_ENABLE_RESET;
            pen_reg <= PORT_ENABLE_RESET;
            safe_reg <= SAFE_RESET;
            {fmode_reg, irq_reg, fcr_reg, erase_reg, bank_reg} <= '0;
        end else begin
            {active_reg, dout_reg, oe_n_reg, bit_reg, idx_reg} <= {active_next,
                dout_next, oe_n_next, bit_next, idx_next};
            {dcnt_reg, shift_reg, tx_reg, byte0_reg, cmd_reg} <= {dcnt_next,
                shift_next, tx_next, byte0_next, cmd_next};
            {hcmd_reg, stat_reg, selector_reg, rdata_reg, addr_reg} <= {hcmd_next,
                stat_next, selector_next, rdata_next, addr_next};
            {wpar_reg, rpar_reg, err_reg, flag_reg, ien_reg, pen_reg} <= {wpar_next,
                rpar_next, err_next, flag_next, ien_next, pen_next};
            {safe_reg, fmode_reg, irq_reg, fcr_reg, erase_reg, bank_reg} <= {safe_next,
                fmode_next, irq_next, fcr_next, erase_next, bank_next};
        end
    end

    // Two-entry write buffer and memory sequencer
    always_comb begin
        {mstate_next, mreq_next, mwe_next, mword_next} = {mstate_reg, mreq_reg,
            mwe_reg, mword_reg};
        {maddr_next, mwdata_next, rdaddr_next, lo_next} = {maddr_reg, mwdata_reg,
            rdaddr_reg, lo_reg};
        {rbuf_next, rbuf_ok_next, rdpend_next} = {rbuf_reg, rbuf_ok_reg, rdpend_reg};
        pop = 1'b0;
        if (take || rd_start) rbuf_ok_next = 1'b0;
        if (rd_start) begin
            rdpend_next = 1'b1;
            rdaddr_next = addr_reg;
        end
        unique case (mstate_reg)
            MEM_IDLE: begin
                if (!fifo_empty) begin
                    pop = 1'b1;
                    if (fmode_reg && !fifo_addr[rptr_reg][0]) begin
                        lo_next = fifo_data[rptr_reg];
                    end else begin
                        mstate_next = MEM_WRITE;
                        {mreq_next, mwe_next} = 2'h3;
                        mword_next = fmode_reg; // [RULE13] [RULE14]
                        maddr_next = fmode_reg ? {fifo_addr[rptr_reg][15:1], 1'b0} :
                            fifo_addr[rptr_reg];
                        mwdata_next = fmode_reg ? {fifo_data[rptr_reg], lo_reg} :
                            {8'h00, fifo_data[rptr_reg]};
                    end
                end else if (rdpend_reg && !rd_start) begin
                    mstate_next = MEM_READ;
                    {mreq_next, mwe_next, mword_next} = 3'h4;
                    maddr_next = rdaddr_reg;
                    rdpend_next = 1'b0;
                end
            end
            MEM_WRITE: begin
                if (mem_ack) begin
                    mstate_next = MEM_IDLE;
                    {mreq_next, mwe_next, mword_next} = 3'h0;
                end
            end
            MEM_READ: begin
                if (mem_ack) begin
                    mstate_next = MEM_IDLE;
                    mreq_next = 1'b0;
                    rbuf_next = mem_rdata;
                    rbuf_ok_next = !rd_start && !rdpend_reg;
                end
            end
            default: mstate_next = MEM_IDLE;
        endcase
        wptr_next = push ? ptr_inc(wptr_reg) : wptr_reg;
        rptr_next = pop ? ptr_inc(rptr_reg) : rptr_reg;
        cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mstate_reg <= MEM_IDLE;
            {mreq_reg, mwe_reg, mword_reg, maddr_reg, mwdata_reg, rdaddr_reg} <= '0;
            {lo_reg, rbuf_reg, rbuf_ok_reg, rdpend_reg} <= '0;
            {wptr_reg, rptr_reg, cnt_reg} <= '0;
        end else begin
            mstate_reg <= mstate_next;
            {mreq_reg, mwe_reg, mword_reg, maddr_reg, mwdata_reg} <= {mreq_next,
                mwe_next, mword_next, maddr_next, mwdata_next};
            {rdaddr_reg, lo_reg, rbuf_reg, rbuf_ok_reg, rdpend_reg} <= {rdaddr_next,
                lo_next, rbuf_next, rbuf_ok_next, rdpend_next};
            {wptr_reg, rptr_reg, cnt_reg} <= {wptr_next, rptr_next, cnt_next};
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            fifo_addr[wptr_reg] <= addr_reg;
            fifo_data[wptr_reg] <= b;
        end
    end

    assign link_dout = dout_reg;
    assign link_dout_oe_n = oe_n_reg;
    assign mpu_rdata = rdata_reg;
    assign mpu_irq = irq_reg;
    assign mem_req = mreq_reg;
    assign mem_we = mwe_reg;
    assign mem_word = mword_reg;
    assign mem_addr = maddr_reg;
    assign mem_wdata = mwdata_reg;
    assign flash_bank_select = bank_reg;
    assign flash_programming_mode = fmode_reg;
    assign flash_ctrl_reset = fcr_reg;
    assign mass_erase_start = erase_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence deselected_s;
        !selected [*2];
    endsequence
    sequence strobe_s;
        strobe_hit;
    endsequence

    safe_window_a: assert property (push && safe_reg && !fmode_reg |-> // [RULE1]
        addr_reg >= SAFE_LO && addr_reg <= SAFE_HI)
        else $error("protected write outside window");
    single_cmd_a: assert property (end_evt && idx_reg == IDX_ADDR_LO && bit_reg == '0 // [RULE2]
        |=> hcmd_reg == $past(byte0_reg))
        else $error("single byte not captured");
    quiet_cmd_a: assert property (end_evt && idx_reg >= IDX_STATUS && // [RULE4]
        cmd_reg[6:0] == 7'h00 |=> $stable(hcmd_reg))
        else $error("quiet command captured");
    flag_set_a: assert property (cap && !fmode_reg |=> flag_reg ##1 (flag_reg || // [RULE6]
        $past(mpu_wr)))
        else $error("flag not set on capture");
    short_count_a: assert property (end_evt && idx_reg != '0 && idx_reg < IDX_DATA // [RULE11]
        |=> stat_reg[4:2] == SHORT_COUNT)
        else $error("short count not 111");
    mode_bit_a: assert property (end_evt && !test_s[1] |=> !stat_reg[STAT_MODE]) // [RULE12]
        else $error("mode bit set with test low");
    entry_a: assert property ($rose(fmode_reg) |-> $past(entry_ok) && fcr_reg) // [RULE18]
        else $error("flash mode entered without permission");
    strobe_clear_a: assert property (strobe_s |=> selector_reg == 8'h00) // [RULE21]
        else $error("selector not cleared by strobe");
    idle_hiz_a: assert property (deselected_s |-> link_dout_oe_n) // [RULE23]
        else $error("output driven while deselected");
    word_even_a: assert property (mem_req && mem_word |-> !mem_addr[0]) // [RULE14]
        else $error("flash word on odd address");
endmodule : spi_slave_memory_port
`default_nettype wire

// [sim/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic port_select_n,
    output logic link_clk,
    output logic link_din,
    input wire logic link_dout
);
    logic [7:0] tx [8];
    logic [7:0] rx [8];
    initial begin
        port_select_n = 1'b1;
        link_clk = 1'b0;
        link_din = 1'b1;
    end
    // Link clock stands still outside frames
    task automatic frame(input int n);
        port_select_n = 1'b0;
        #400;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                link_din = tx[b][i];
                #100 link_clk = 1'b1;
                #90 rx[b][i] = link_dout;
                #10 link_clk = 1'b0;
            end
        end
        #400 port_select_n = 1'b1;
        link_din = ~link_din;
        #400;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [sim/tb_spi_slave_memory_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_memory_port;
    import spi_port_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, mpu_wr = 1'b0, mpu_rd = 1'b0, mem_ack = 1'b0;
    logic test_pin = 1'b1, emu = 1'b1, erased = 1'b0, sel_n, lclk, din, dout, oe_n;
    logic boot = 1'b0, lock = 1'b0;
    logic [3:0] key = FLASH_KEY;
    logic irq, req, we, word, mode, fl_rst, erase;
    logic [15:0] mpu_addr = 16'h0000, maddr, mwdata;
    logic [32:0] last = 33'h000000000;
    logic [7:0] mpu_wdata = 8'h00, mem_rdata = 8'h00, mpu_rdata, rd;
    logic [1:0] bank;
    int fail_count = 0, n_checks = 0, n_wr = 0, n_rst = 0;
    always #12.5 core_clk = ~core_clk;
    spi_host_model i_spi_host_model (.port_select_n(sel_n), .link_clk(lclk),
        .link_din(din), .link_dout(oe_n ? ~dout : dout));
    spi_slave_memory_port i_spi_slave_memory_port (.core_clk(core_clk), .rst(rst),
        .port_select_n(sel_n), .link_clk(lclk), .link_din(din), .link_dout(dout),
        .link_dout_oe_n(oe_n), .test_pin(test_pin), .emulation_enable_pin(emu),
        .boot_phase_flag(boot), .readback_lock(lock), .flash_write_key(key),
        .flash_ready(1'b1), .mpu_addr(mpu_addr), .mpu_wr(mpu_wr), .mpu_rd(mpu_rd),
        .mpu_wdata(mpu_wdata), .mpu_rdata(mpu_rdata), .mpu_irq(irq), .mem_req(req),
        .mem_we(we), .mem_word(word), .mem_addr(maddr), .mem_wdata(mwdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .flash_bank_select(bank),
        .flash_programming_mode(mode), .flash_ctrl_reset(fl_rst), .mass_erase_start(erase));
    // Memory answers each request one cycle later
    always @(negedge core_clk) begin
        mem_ack <= req && !mem_ack;
        mem_rdata <= maddr[7:0] ^ 8'hA5;
        if (req && !mem_ack && we) begin
            n_wr <= n_wr + 1;
            last <= {word, maddr, mwdata};
        end
        if (erase) erased <= 1'b1;
        if (fl_rst) n_rst <= n_rst + 1;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        mpu_addr = a;
        mpu_wdata = d;
        mpu_wr = 1'b1;
        @(negedge core_clk);
        mpu_wr = 1'b0;
    endtask : reg_wr
    task automatic rcheck(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge core_clk);
        mpu_addr = a;
        mpu_rd = 1'b1;
        @(negedge core_clk);
        mpu_rd = 1'b0;
        check(mpu_rdata & m, e);
    endtask : rcheck
    task automatic xfer(input logic [7:0] q [$]);
        foreach (q[i]) i_spi_host_model.tx[i] = q[i];
        i_spi_host_model.frame(q.size());
    endtask : xfer
    task automatic stop_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        rcheck(STATUS_OFFSET, 8'hFF, STATUS_RESET);
        rcheck(PORT_CTRL_OFFSET, 8'h18, 8'h10);
        rcheck(IRQ_ENABLE_OFFSET, 8'h80, 8'h00);
        rcheck(16'h1234, 8'hFF, 8'h00);
        xfer('{8'h5A});
        rcheck(CMD_OFFSET, 8'hFF, 8'h5A);
        check(oe_n, 1'b1);
        rcheck(STATUS_OFFSET, 8'hFF, 8'h1D);
        reg_wr(IRQ_ENABLE_OFFSET, 8'h80);
        reg_wr(FLAG_OFFSET, 8'hFF);
        rcheck(FLAG_OFFSET, 8'h80, 8'h80);
        check(irq, 1'b1);
        reg_wr(FLAG_OFFSET, 8'h00);
        repeat (2) @(negedge core_clk);
        check(irq, 1'b0);
        xfer('{8'h04, 8'h00, 8'h01, 8'h00, 8'h54, 8'h33});
        check(last, 33'h004010033);
        check(33'(n_wr), 33'h2);
        rcheck(STATUS_OFFSET, 8'hBF, 8'h29);
        rcheck(CMD_OFFSET, 8'hFF, 8'h01);
        reg_wr(FLAG_OFFSET, 8'h00);
        xfer('{8'h00, 8'h11, 8'h80, 8'h00, 8'h00, 8'h00});
        check(i_spi_host_model.rx[3] & 8'hBF, 8'h29);
        check(i_spi_host_model.rx[4], 8'hB4);
        check(i_spi_host_model.rx[5], 8'hB7);
        rcheck(STATUS_OFFSET, 8'hFF, 8'h29);
        rcheck(FLAG_OFFSET, 8'h80, 8'h00);
        reg_wr(PORT_CTRL_OFFSET, 8'h18);
        xfer('{8'h05, 8'h00, 8'h02, 8'h00, 8'h11});
        rcheck(STATUS_OFFSET, 8'h80, 8'h80);
        xfer('{8'h04, 8'h0F, 8'h02, 8'h00, 8'h22});
        check(last, 33'h0040F0022);
        check(33'(n_wr), 33'h3);
        rcheck(STATUS_OFFSET, 8'h80, 8'h00);
        reg_wr(PORT_CTRL_OFFSET, 8'h10);
        reg_wr(FLAG_OFFSET, 8'h00);
        reg_wr(SELECTOR_OFFSET, SEL_ERASE);
        xfer('{8'h20, 8'h81, 8'h00, 8'h00, STROBE_KEY});
        xfer('{8'h20, 8'h80, 8'h00, 8'h00, SEL_ERASE});
        xfer('{8'h20, 8'h81, 8'h00, 8'h00, 8'h95});
        xfer('{8'h20, 8'h81, 8'h00, 8'h00, STROBE_KEY});
        for (int k = 0; k < 5; k++) begin
            emu = (k != 0);
            boot = (k == 1);
            key = (k == 2) ? 4'h3 : FLASH_KEY;
            lock = (k == 3);
            xfer('{8'h20, 8'h80, 8'h00, 8'h00, (k == 4) ? SEL_ERASE : SEL_READBACK});
            xfer('{8'h20, 8'h81, 8'h00, 8'h00, STROBE_KEY});
            check(mode, k == 4);
        end
        check(erased, 1'b1);
        check(33'(n_rst), 33'h1);
        xfer('{8'h00, 8'h10, 8'h00, 8'h00, 8'hAB, 8'hCD});
        check(last, 33'h10010CDAB);
        rcheck(STATUS_OFFSET, 8'h03, 8'h03);
        test_pin = 1'b0;
        xfer('{8'h03});
        rcheck(STATUS_OFFSET, 8'h02, 8'h00);
        check(bank, 2'h3);
        rcheck(FLAG_OFFSET, 8'h80, 8'h00);
        stop_test;
    end
endmodule : tb_spi_slave_memory_port
`default_nettype wire
